// ==== core/pbpc_pkg.sv ====
package pbpc_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ            = 125_000_000;
	localparam int CYC_PER_US        = CLK_HZ / 1_000_000;
	localparam int TICK_TIME_US      = 1000;
	localparam int TICK_CYCLES       = CYC_PER_US * TICK_TIME_US;
	localparam int INT_PULSE_US      = 128;
	localparam int INT_PULSE_CYCLES  = CYC_PER_US * INT_PULSE_US;
	localparam int CLIM_TIME_US      = 1000;
	localparam int CLIM_CYCLES       = int'((CLK_HZ * 64'(CLIM_TIME_US) + 999_999) / 1_000_000);
	localparam int SHORT_OPEN_US     = 200;
	localparam int SHORT_OPEN_CYCLES = (CLK_HZ / 1000) * SHORT_OPEN_US / 1000;
	localparam int WDOG_TIME_S       = 14;
	localparam int WDOG_MS           = WDOG_TIME_S * 1000;
	localparam int CYCLE_OFF_MS      = 500;

	// ----------------------------------------
	// Counter widths and reset values
	// ----------------------------------------
	localparam int CNT_W             = 17;
	localparam int MS_W              = 16;
	localparam logic RST_WDOG_EN     = 1'h0;
	localparam logic RST_RAIL_MODE   = 1'h0;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum {ST_SHIP, ST_WAKE, ST_ACTIVE, ST_CYCLE} pbpc_state_t;

	typedef enum logic [1:0] {
		LP_CYCLE = 2'h0,
		LP_NONE  = 2'h1,
		LP_SHIP  = 2'h2
	} pbpc_lp_action_t;

	typedef enum logic [1:0] {
		SRC_INPUT    = 2'h0,
		SRC_BATTERY  = 2'h1,
		SRC_PULLDOWN = 2'h2,
		SRC_FLOAT    = 2'h3
	} pbpc_src_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic                 outputRailEnable;
		logic                 railSwitchSelect;
		logic [1:0]           systemRailSourceSelect;
		logic [2:0]           systemRailTarget;
		logic [MS_W-1:0]      firstPressMs;
		logic [MS_W-1:0]      secondPressMs;
		logic [MS_W-1:0]      longPressMs;
		logic [MS_W-1:0]      longPressWarnMs;
		logic [1:0]           longPressAction;
		logic                 resetNeedsInputPower;
		logic                 adapterWatchdogEnable;
	} pbpc_cfg_t;

	typedef struct packed {
		logic firstPress;
		logic secondPress;
		logic longPressWarn;
		logic currentLimit;
	} pbpc_flags_t;

	typedef struct packed {
		logic ioSupplyEnable;
		logic railFromInput;
		logic railFromBattery;
		logic railPulldown;
		logic inputPathEnable;
		logic softStart;
		logic auxEnable;
		logic auxLoadSwitch;
		logic auxPulldown;
		logic batteryTracking;
	} pbpc_rail_t;

endpackage : pbpc_pkg

// ==== core/pbpc_power_ctrl.sv ====
// Contract
// R01: Aux off pulls down; select picks regulator/switch
// R02: Current limit held 1 ms sets flag
// R03: Host disables aux after limit interrupt
// R04: Mode change applies only while aux disabled
// R05: Short opens input 200 us, then softstart
// R06: Source select: input, battery, pulldown, float
// R07: Target code 000 selects battery tracking
// R08: IO supply on except in ship mode
// R09: Running timer keeps its old duration
// R10: First timer sets flag, 128 us pulse
// R11: Second timer sets flag and interrupts only
// R12: Flags clear on read; set alone interrupts
// R13: Ship press enables IO, wakes on expiry
// R14: Early release during wake returns to ship
// R15: Held button after wake is ignored
// R16: Valid adapter before second expiry exits ship
// R17: Long timer expiry performs chosen action
// R18: Warning flag and interrupt before long expiry
// R19: No switch to power cycle mid-press
// R20: Power cycle gated by input for press
// R21: Request starts power cycle; IO stays on
// R22: Adapter watchdog cycles power after 14 s
// R23: Watchdog enable resets disabled
// R24: Each interrupt one 128 us low pulse
// R25: Release resets all press timers
`timescale 1ns/1ps
`default_nettype none

module pbpc_power_ctrl
	import pbpc_pkg::*;
#(
	parameter int TICK_CYC  = TICK_CYCLES,
	parameter int PULSE_CYC = INT_PULSE_CYCLES,
	parameter int CLIM_CYC  = CLIM_CYCLES,
	parameter int SHORT_CYC = SHORT_OPEN_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	// Pins and analog comparators
	input  wire logic        buttonInputN,
	input  wire logic        adapterValid,
	input  wire logic        currentLimitActive,
	input  wire logic        railShortDetect,
	// Host control
	input  var  pbpc_cfg_t   cfg,
	input  var  pbpc_flags_t intMask,
	input  var  pbpc_flags_t flagRead,
	input  wire logic        powerCycleRequest,
	input  wire logic        busTransaction,
	// Status
	output pbpc_flags_t      flags,
	output logic             shipMode,
	// Power controls
	output pbpc_rail_t       rail,
	// Open-drain interrupt
	output logic             interruptOut,
	output logic             interruptOeN
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	pbpc_state_t     state;
	logic            btnMeta, btnSync, adMeta, adSync, adPrev;
	logic            climMeta, climSync, shMeta, shSync, shPrev;
	logic [CNT_W-1:0] tickCnt, climCnt, openCnt, pulseCnt;
	logic            msTick, pressed, armed, awake, vinOk;
	logic            t1Exp, t1Done, t2Exp, t2Done, twExp, tlExp;
	logic [MS_W-1:0] warnDur, cycCnt, wdCnt;
	logic [1:0]      lpAct;
	logic            wdRun, wdExp, cycleGo, climSet, pend;
	logic            auxMode;
	pbpc_flags_t     setEv, newEv;
	pbpc_rail_t      next_rail;

	function automatic logic nextFlag(input logic flag, input logic set, input logic rd);
		nextFlag = set | (flag & ~rd);
	endfunction : nextFlag

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			btnMeta  <= 1'h1;
			btnSync  <= 1'h1;
			adMeta   <= 1'h0;
			adSync   <= 1'h0;
			climMeta <= 1'h0;
			climSync <= 1'h0;
			shMeta   <= 1'h0;
			shSync   <= 1'h0;
		end else if (clkEn) begin
			btnMeta  <= buttonInputN;
			btnSync  <= btnMeta;
			adMeta   <= adapterValid;
			adSync   <= adMeta;
			climMeta <= currentLimitActive;
			climSync <= climMeta;
			shMeta   <= railShortDetect;
			shSync   <= shMeta;
		end
	end

	assign pressed = ~btnSync;
	assign awake   = (state == ST_ACTIVE) || (state == ST_CYCLE);

	// ----------------------------------------
	// Millisecond tick
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tickCnt <= '0;
		end else if (clkEn) begin
			tickCnt <= (tickCnt == CNT_W'(TICK_CYC - 1)) ? '0 : tickCnt + CNT_W'(1);
		end
	end

	assign msTick = (tickCnt == CNT_W'(TICK_CYC - 1));

	// ----------------------------------------
	// Press timers
	// ----------------------------------------
	assign warnDur = (cfg.longPressMs > cfg.longPressWarnMs) ?
		cfg.longPressMs - cfg.longPressWarnMs : '0;

	pbpc_press_timer uFirst (.clk(clk), .nrst(nrst), .clkEn(clkEn), .msTick(msTick),
		.run(pressed), .duration(cfg.firstPressMs), .expired(t1Exp), .done(t1Done));
	pbpc_press_timer uSecond (.clk(clk), .nrst(nrst), .clkEn(clkEn), .msTick(msTick),
		.run(pressed), .duration(cfg.secondPressMs), .expired(t2Exp), .done(t2Done));
	pbpc_press_timer uWarn (.clk(clk), .nrst(nrst), .clkEn(clkEn), .msTick(msTick),
		.run(pressed), .duration(warnDur), .expired(twExp), .done());
	pbpc_press_timer uLong (.clk(clk), .nrst(nrst), .clkEn(clkEn), .msTick(msTick),
		.run(pressed), .duration(cfg.longPressMs), .expired(tlExp), .done());

	// ----------------------------------------
	// Press bookkeeping
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed <= 1'h1;
			vinOk <= 1'h0;
			lpAct <= LP_CYCLE;
		end else if (clkEn) begin
			if (!pressed) begin
				armed <= 1'h1;
			end else if ((state == ST_WAKE && t1Exp) ||
				(state == ST_ACTIVE && tlExp && lpAct == LP_SHIP)) begin
				armed <= 1'h0; // [R15]
			end
			if (!pressed) begin
				vinOk <= adSync;
			end else if (!adSync) begin
				vinOk <= 1'h0; // [R20]
			end
			if (!pressed || cfg.longPressAction != LP_CYCLE) begin
				lpAct <= cfg.longPressAction; // [R19]
			end
		end
	end

	assign cycleGo = (tlExp && armed && state == ST_ACTIVE && lpAct == LP_CYCLE &&
		(!cfg.resetNeedsInputPower || vinOk)) // [R17] [R20]
		|| (powerCycleRequest && awake) || wdExp; // [R21] [R22]

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state  <= ST_ACTIVE;
			cycCnt <= '0;
		end else if (clkEn) begin
			case (state)
				ST_SHIP: begin
					if (adSync) begin
						state <= ST_ACTIVE; // [R16]
					end else if (pressed && armed) begin
						state <= ST_WAKE; // [R13]
					end
				end
				ST_WAKE: begin
					if (adSync && !t2Done) begin
						state <= ST_ACTIVE; // [R16]
					end else if (t1Exp) begin
						state <= ST_ACTIVE; // [R13]
					end else if (!pressed) begin
						state <= ST_SHIP; // [R14]
					end
				end
				ST_ACTIVE: begin
					if (cycleGo) begin
						state  <= ST_CYCLE;
						cycCnt <= '0;
					end else if (tlExp && armed && lpAct == LP_SHIP) begin
						state <= ST_SHIP; // [R17]
					end
				end
				ST_CYCLE: begin
					if (msTick) begin
						cycCnt <= cycCnt + MS_W'(1);
						if (cycCnt + MS_W'(1) >= MS_W'(CYCLE_OFF_MS)) begin
							state <= ST_ACTIVE;
						end
					end
				end
				default: state <= ST_ACTIVE;
			endcase
		end
	end

	// ----------------------------------------
	// Adapter watchdog
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			adPrev <= 1'h0;
			wdRun  <= RST_WDOG_EN; // [R23]
			wdCnt  <= '0;
			wdExp  <= 1'h0;
		end else if (clkEn) begin
			adPrev <= adSync;
			wdExp  <= 1'h0;
			if (!cfg.adapterWatchdogEnable || busTransaction || !adSync) begin
				wdRun <= 1'h0; // [R23]
			end else if (adSync && !adPrev) begin
				wdRun <= 1'h1; // [R22]
				wdCnt <= '0;
			end else if (wdRun && msTick) begin
				wdCnt <= wdCnt + MS_W'(1);
				if (wdCnt + MS_W'(1) >= MS_W'(WDOG_MS)) begin
					wdRun <= 1'h0;
					wdExp <= (state == ST_ACTIVE); // [R22]
				end
			end
		end
	end

	// ----------------------------------------
	// Current limit qualification
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			climCnt <= '0;
		end else if (clkEn) begin
			if (!climSync || !rail.auxEnable) begin
				climCnt <= '0;
			end else if (climCnt != CNT_W'(CLIM_CYC)) begin
				climCnt <= climCnt + CNT_W'(1); // [R02]
			end
		end
	end

	assign climSet = (climCnt == CNT_W'(CLIM_CYC - 1)) && climSync && rail.auxEnable;

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	always_comb begin
		setEv.firstPress    = t1Exp && armed && awake;  // [R10]
		setEv.secondPress   = t2Exp && armed && awake;  // [R11]
		setEv.longPressWarn = twExp && armed && awake;  // [R18]
		setEv.currentLimit  = climSet;                  // [R02]
		newEv               = setEv & ~flags;           // [R12]
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flags <= '0;
		end else if (clkEn) begin
			flags.firstPress    <= nextFlag(flags.firstPress, setEv.firstPress,
				flagRead.firstPress); // [R12]
			flags.secondPress   <= nextFlag(flags.secondPress, setEv.secondPress,
				flagRead.secondPress);
			flags.longPressWarn <= nextFlag(flags.longPressWarn, setEv.longPressWarn,
				flagRead.longPressWarn);
			flags.currentLimit  <= nextFlag(flags.currentLimit, setEv.currentLimit,
				flagRead.currentLimit);
		end
	end

	// ----------------------------------------
	// Interrupt pulse
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend         <= 1'h0;
			pulseCnt     <= '0;
			interruptOeN <= 1'h1;
			interruptOut <= 1'h0;
		end else if (clkEn) begin
			pend <= (|(newEv & ~intMask)) || (pend && pulseCnt != '0); // [R24]
			if (pulseCnt != '0) begin
				pulseCnt <= pulseCnt - CNT_W'(1);
				if (pulseCnt == CNT_W'(1)) begin
					interruptOeN <= 1'h1;
				end
			end else if (pend) begin
				pulseCnt     <= CNT_W'(PULSE_CYC); // [R10] [R24]
				interruptOeN <= 1'h0;
			end
		end
	end

	// ----------------------------------------
	// System rail short handling
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shPrev  <= 1'h0;
			openCnt <= '0;
		end else if (clkEn) begin
			shPrev <= shSync;
			if (shSync && !shPrev && state == ST_ACTIVE) begin
				openCnt <= CNT_W'(SHORT_CYC); // [R05]
			end else if (openCnt != '0) begin
				openCnt <= openCnt - CNT_W'(1);
			end
		end
	end

	// ----------------------------------------
	// Auxiliary output mode
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			auxMode <= RST_RAIL_MODE;
		end else if (clkEn && !cfg.outputRailEnable) begin
			auxMode <= cfg.railSwitchSelect; // [R04]
		end
	end

	// ----------------------------------------
	// Rail controls
	// ----------------------------------------
	always_comb begin
		next_rail                 = '0;
		next_rail.ioSupplyEnable  = (state != ST_SHIP); // [R08] [R13] [R21]
		next_rail.inputPathEnable = (openCnt == '0);    // [R05]
		next_rail.softStart       = (openCnt == CNT_W'(1));
		next_rail.batteryTracking = (cfg.systemRailTarget == 3'h0); // [R07]
		if (state == ST_ACTIVE) begin
			case (pbpc_src_t'(cfg.systemRailSourceSelect)) // [R06]
				SRC_INPUT: begin
					next_rail.railFromInput   = adSync && (openCnt == '0);
					next_rail.railFromBattery = !adSync;
				end
				SRC_BATTERY:  next_rail.railFromBattery = 1'h1;
				SRC_PULLDOWN: next_rail.railPulldown    = 1'h1;
				default:      next_rail.railPulldown    = 1'h0;
			endcase
			next_rail.auxEnable = cfg.outputRailEnable; // [R01]
		end else begin
			next_rail.railPulldown = 1'h1;
		end
		next_rail.auxLoadSwitch = next_rail.auxEnable && auxMode; // [R01]
		next_rail.auxPulldown   = !next_rail.auxEnable;          // [R01]
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rail     <= '0;
			shipMode <= 1'h0;
		end else if (clkEn) begin
			rail     <= next_rail;
			shipMode <= (state == ST_SHIP);
		end
	end

endmodule : pbpc_power_ctrl

`default_nettype wire

// ==== core/pbpc_press_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module pbpc_press_timer
	import pbpc_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            nrst,
	input  wire logic            clkEn,
	// Timing
	input  wire logic            msTick,
	input  wire logic            run,
	input  wire logic [MS_W-1:0] duration,
	// Result
	output logic                 expired,
	output logic                 done
);

	logic [MS_W-1:0] durLatched;
	logic [MS_W-1:0] count;

	// ----------------------------------------
	// Duration held for the whole press
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			durLatched <= '0;
		end else if (clkEn && !run) begin
			durLatched <= duration; // [R09]
		end
	end

	// ----------------------------------------
	// Count, cleared on release
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count   <= '0;
			done    <= 1'h0;
			expired <= 1'h0;
		end else if (clkEn) begin
			expired <= 1'h0;
			if (!run) begin
				count <= '0; // [R25]
				done  <= 1'h0;
			end else if (!done && msTick) begin
				count <= count + MS_W'(1);
				if (count + MS_W'(1) >= durLatched) begin
					done    <= 1'h1;
					expired <= 1'h1;
				end
			end
		end
	end

endmodule : pbpc_press_timer

`default_nettype wire

// ==== test/pbpc_button.sv ====
`timescale 1ns/1ps
`default_nettype none

module pbpc_button (
	// Clock
	input  wire logic clk,
	// Pin, pulled up when idle
	output var  logic buttonInputN
);
	initial buttonInputN = 1'b1;

	task automatic push();
		@(negedge clk);
		buttonInputN = 1'b0;
	endtask : push

	task automatic lift();
		@(negedge clk);
		buttonInputN = 1'b1;
	endtask : lift
endmodule : pbpc_button

`default_nettype wire

// ==== test/pbpc_power_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module pbpc_power_ctrl_chk
	import pbpc_pkg::*;
#(
	parameter int PULSE_CYC = 8,
	parameter int CLIM_CYC  = 20,
	parameter int SHORT_CYC = 5
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Watched ports
	input wire logic        buttonInputN,
	input wire logic        currentLimitActive,
	input var  pbpc_cfg_t   cfg,
	input var  pbpc_flags_t intMask,
	input var  pbpc_flags_t flags,
	input wire logic        shipMode,
	input var  pbpc_rail_t  rail,
	input wire logic        interruptOut,
	input wire logic        interruptOeN
);
	int lowCnt;
	int climCnt;
	int maskCnt;
	int openCnt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) lowCnt <= 0;
		else lowCnt <= interruptOeN ? 0 : lowCnt + 1;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) climCnt <= 0;
		else climCnt <= (rail.auxEnable && currentLimitActive) ? climCnt + 1 : 0;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) maskCnt <= 0;
		else maskCnt <= (&intMask) ? maskCnt + 1 : 0;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) openCnt <= 0;
		else openCnt <= !rail.inputPathEnable ? openCnt + 1 : (rail.softStart ? openCnt : 0);
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	pulse_width_a: assert property ($rose(interruptOeN) |-> lowCnt == PULSE_CYC)
		else $error("interrupt pulse length wrong");
	pin_drive_a: assert property (interruptOut == 1'b0)
		else $error("interrupt pin drives high");
	flag_pulse_a: assert property ($rose(flags.firstPress) && !intMask.firstPress && interruptOeN
		|-> ##2 !interruptOeN) else $error("no pulse after press flag");
	mask_quiet_a: assert property (maskCnt > 2 * PULSE_CYC + 6 |-> interruptOeN)
		else $error("pulse while all masked");
	clim_early_a: assert property ($rose(flags.currentLimit) |-> climCnt >= CLIM_CYC)
		else $error("limit flag too early");
	clim_late_a: assert property (climCnt == CLIM_CYC + 6 |-> flags.currentLimit)
		else $error("limit flag missing");
	short_open_a: assert property (rail.softStart
		|-> openCnt inside {[SHORT_CYC - 1:SHORT_CYC + 1]}) else $error("open time wrong");
	io_ship_a: assert property ($fell(rail.ioSupplyEnable) |-> ##[0:1] shipMode)
		else $error("io supply off outside ship");
	ship_wake_a: assert property (shipMode && $fell(buttonInputN)
		|-> ##[1:5] rail.ioSupplyEnable) else $error("io supply not on at press");
	aux_off_a: assert property ((!shipMode && !cfg.outputRailEnable) [*2]
		|-> rail.auxPulldown && !rail.auxEnable) else $error("aux not pulled down");
endmodule : pbpc_power_ctrl_chk

bind pbpc_power_ctrl pbpc_power_ctrl_chk #(
	.PULSE_CYC(PULSE_CYC), .CLIM_CYC(CLIM_CYC), .SHORT_CYC(SHORT_CYC)
) chk_u (
	.clk(clk), .nrst(nrst), .buttonInputN(buttonInputN),
	.currentLimitActive(currentLimitActive), .cfg(cfg), .intMask(intMask),
	.flags(flags), .shipMode(shipMode), .rail(rail),
	.interruptOut(interruptOut), .interruptOeN(interruptOeN)
);

`default_nettype wire

// ==== test/pbpc_power_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
	end \
end

module pbpc_power_ctrl_test
	import pbpc_pkg::*;
;
	localparam int TICK = 5;
	logic        clk, nrst, adapterValid, currentLimitActive, railShortDetect;
	logic        powerCycleRequest, busTransaction, buttonInputN, clkEn;
	logic        shipMode, interruptOut, interruptOeN;
	pbpc_cfg_t   cfg;
	pbpc_flags_t intMask, flagRead, flags;
	pbpc_rail_t  rail;
	int          n_mismatch, tests_run, nInt, n0;

	pbpc_power_ctrl #(.TICK_CYC(TICK), .PULSE_CYC(8), .CLIM_CYC(20), .SHORT_CYC(5)) dut_u (
		.clk(clk), .nrst(nrst), .clkEn(clkEn), .buttonInputN(buttonInputN),
		.adapterValid(adapterValid), .currentLimitActive(currentLimitActive),
		.railShortDetect(railShortDetect), .cfg(cfg), .intMask(intMask),
		.flagRead(flagRead), .powerCycleRequest(powerCycleRequest),
		.busTransaction(busTransaction), .flags(flags), .shipMode(shipMode),
		.rail(rail), .interruptOut(interruptOut), .interruptOeN(interruptOeN)
	);
	pbpc_button btn_u (.clk(clk), .buttonInputN(buttonInputN));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(negedge interruptOeN) if (nrst) nInt++;

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic ms(input int n);
		cyc(n * TICK);
	endtask : ms
	task automatic clear_flags();
		flagRead = pbpc_flags_t'(4'hF);
		cyc(1);
		flagRead = '0;
	endtask : clear_flags
	task automatic done(input string s);
		$display("test %s finished, %0d checks", s, tests_run);
	endtask : done
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	initial begin
		#1ms;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		{nrst, adapterValid, currentLimitActive, railShortDetect} = '0;
		clkEn = 1'b1;
		{powerCycleRequest, busTransaction} = '0;
		{intMask, flagRead} = '0;
		cfg = '0;
		cfg.railSwitchSelect = 1'b1;
		cfg.systemRailTarget = 3'h1;
		cfg.firstPressMs = 16'h0003;
		cfg.secondPressMs = 16'h0005;
		cfg.longPressMs = 16'h0014;
		cfg.longPressWarnMs = 16'h0003;
		cfg.longPressAction = LP_NONE;
		cyc(6);
		nrst = 1'b1;
		cyc(3);
		// ----------------------------------------
		// Aux output and current limit
		// ----------------------------------------
		`CHK("aux pulldown", 1'b1, rail.auxPulldown);
		cfg.outputRailEnable = 1'b1;
		cyc(3);
		`CHK("aux switch", 2'b11, {rail.auxEnable, rail.auxLoadSwitch});
		cfg.railSwitchSelect = 1'b0;
		cyc(3);
		`CHK("mode held", 1'b1, rail.auxLoadSwitch);
		currentLimitActive = 1'b1;
		cyc(30);
		`CHK("limit flag", 2'b11, {flags.currentLimit, rail.auxEnable});
		currentLimitActive = 1'b0;
		cfg.outputRailEnable = 1'b0;
		cyc(3);
		cfg.outputRailEnable = 1'b1;
		cyc(3);
		`CHK("aux regulator", 2'b10, {rail.auxEnable, rail.auxLoadSwitch});
		clkEn = 1'b0;
		cfg.systemRailTarget = 3'h0;
		cyc(4);
		`CHK("frozen", 1'b0, rail.batteryTracking);
		clkEn = 1'b1;
		cfg.systemRailTarget = 3'h1;
		clear_flags();
		done("aux");
		// ----------------------------------------
		// Rail source, target and short
		// ----------------------------------------
		adapterValid = 1'b1;
		busTransaction = 1'b1;
		cyc(1);
		busTransaction = 1'b0;
		for (int i = 0; i < 4; i++) begin
			cfg.systemRailSourceSelect = 2'(i);
			cyc(4);
			`CHK("source", {i == 0, i == 1, i == 2}, {rail.railFromInput, rail.railFromBattery, rail.railPulldown});
		end
		cfg.systemRailSourceSelect = SRC_INPUT;
		cfg.systemRailTarget = 3'h0;
		cyc(3);
		`CHK("tracking", 1'b1, rail.batteryTracking);
		cfg.systemRailTarget = 3'h1;
		railShortDetect = 1'b1;
		cyc(1);
		railShortDetect = 1'b0;
		cyc(4);
		`CHK("path open", 2'b00, {rail.inputPathEnable, rail.railFromInput});
		cyc(3);
		`CHK("soft start", 2'b01, {rail.inputPathEnable, rail.softStart});
		cyc(5);
		`CHK("path closed", 2'b10, {rail.inputPathEnable, rail.batteryTracking});
		done("rail");
		// ----------------------------------------
		// Short press timers and flags
		// ----------------------------------------
		n0 = nInt;
		btn_u.push();
		cyc(6);
		cfg.firstPressMs = 16'h0028;
		ms(8);
		`CHK("press flags", 2'b11, {flags.firstPress, flags.secondPress});
		`CHK("press pulses", 2, nInt - n0);
		btn_u.lift();
		cfg.firstPressMs = 16'h0003;
		cyc(4);
		n0 = nInt;
		btn_u.push();
		ms(8);
		btn_u.lift();
		`CHK("no repeat pulse", 0, nInt - n0);
		clear_flags();
		cyc(2);
		`CHK("flags read", 4'h0, flags);
		intMask = pbpc_flags_t'(4'hF);
		btn_u.push();
		ms(8);
		btn_u.lift();
		`CHK("masked flag", 1'b1, flags.firstPress);
		`CHK("masked pulse", 0, nInt - n0);
		clear_flags();
		intMask = '0;
		done("press");
		// ----------------------------------------
		// Long press and power cycles
		// ----------------------------------------
		btn_u.push();
		ms(3);
		cfg.longPressAction = LP_CYCLE;
		ms(22);
		`CHK("no late cycle", 2'b01, {rail.railPulldown, flags.longPressWarn});
		btn_u.lift();
		cfg.resetNeedsInputPower = 1'b1;
		adapterValid = 1'b0;
		btn_u.push();
		ms(25);
		`CHK("gated cycle", 1'b0, rail.railPulldown);
		btn_u.lift();
		cfg.resetNeedsInputPower = 1'b0;
		btn_u.push();
		ms(25);
		`CHK("long cycle", 2'b11, {rail.railPulldown, rail.ioSupplyEnable});
		btn_u.lift();
		ms(505);
		`CHK("cycle over", 1'b0, rail.railPulldown);
		powerCycleRequest = 1'b1;
		cyc(1);
		powerCycleRequest = 1'b0;
		cyc(5);
		`CHK("request cycle", 2'b11, {rail.railPulldown, rail.ioSupplyEnable});
		ms(505);
		clear_flags();
		done("long");
		// ----------------------------------------
		// Ship mode entry and wake
		// ----------------------------------------
		cfg.longPressAction = LP_SHIP;
		btn_u.push();
		ms(25);
		`CHK("ship entry", 3'b100, {shipMode, rail.ioSupplyEnable, rail.auxEnable});
		btn_u.lift();
		cyc(6);
		btn_u.push();
		cyc(5);
		`CHK("wake io", 1'b1, rail.ioSupplyEnable);
		btn_u.lift();
		cyc(6);
		`CHK("back to ship", 3'b100, {shipMode, rail.railFromBattery, rail.auxEnable});
		clear_flags();
		n0 = nInt;
		btn_u.push();
		ms(30);
		`CHK("woken", 3'b011, {shipMode, rail.railFromBattery, rail.auxEnable});
		`CHK("wake quiet", 0, nInt - n0);
		btn_u.lift();
		cyc(6);
		btn_u.push();
		ms(25);
		btn_u.lift();
		adapterValid = 1'b1;
		cyc(6);
		`CHK("adapter exit", 1'b0, shipMode);
		done("ship");
		// ----------------------------------------
		// Adapter watchdog
		// ----------------------------------------
		cfg.adapterWatchdogEnable = 1'b1;
		adapterValid = 1'b0;
		cyc(4);
		adapterValid = 1'b1;
		ms(13995);
		`CHK("watchdog early", 1'b0, rail.railPulldown);
		ms(10);
		`CHK("watchdog cycle", 1'b1, rail.railPulldown);
		done("watchdog");
		report_and_stop();
	end
endmodule : pbpc_power_ctrl_test

`default_nettype wire
